// >>> mem_map_pkg.sv
package mem_map_pkg;
  // program store geometry
  localparam int PROG_WORDS = 512;
  localparam int PROG_WIDTH = 12;
  localparam int PROG_ADDR_W = 9;
  localparam logic [8:0] RESET_VECTOR = 9'h000;
  localparam logic [8:0] LAST_PAGE_BASE = 9'h100;
  // data memory map
  localparam int DATA_ADDR_W = 5;
  localparam logic [4:0] SFR_FIRST = 5'h00;
  localparam logic [4:0] SFR_LAST = 5'h0f;
  localparam logic [4:0] GPR_FIRST = 5'h10;
  localparam logic [4:0] GPR_LAST = 5'h1f;
  localparam int GPR_BYTES = 16;
  // special registers kept in this block, except the indirect one, which reads as zero
  localparam logic [4:0] SFR_INDIRECT = 5'h00;
  localparam logic [4:0] SFR_POINTER = 5'h01;
  localparam logic [4:0] SFR_PC_LOW = 5'h06;
  localparam logic [4:0] SFR_TABLE_PTR = 5'h07;
  localparam logic [4:0] SFR_STATUS = 5'h0a;
  localparam logic [7:0] STATUS_WR_MASK = 8'h0f; // flag bits above are ro
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNUSED_READ = 8'h00;
  // data memory operation
  typedef enum logic [1:0] {
    DOP_NONE = 2'h0,
    DOP_WRITE = 2'h1,
    DOP_BSET = 2'h2,
    DOP_BCLR = 2'h3
  } dop_t;
  typedef struct packed {
    dop_t op;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } dmem_req_t;
  // table read request
  typedef struct packed {
    logic start;
    logic last_page; // 1: last page, 0: current page
    logic [4:0] dest;
  } tbl_req_t;
endpackage

// >>> mem_map.sv
`timescale 1ns/1ps
module mem_map #(
  parameter int CYCLES_PER_INSTR = 4
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // instruction fetch
  input wire logic FETCH_I,
  input wire logic PC_LOAD_I,
  input wire logic [8:0] PC_LOAD_VAL_I,
  output logic [8:0] PC_O,
  output logic [11:0] INSTR_O,
  // data memory port
  input wire mem_map_pkg::dmem_req_t DMEM_REQ_I,
  output logic [7:0] DMEM_RDATA_O,
  // table read
  input wire mem_map_pkg::tbl_req_t TBL_REQ_I,
  output logic TBL_BUSY_O,
  output logic TBL_DONE_O,
  // program store load path
  input wire logic PROG_WE_I,
  input wire logic [8:0] PROG_WADDR_I,
  input wire logic [11:0] PROG_WDATA_I,
  // serial pins
  input wire logic DEBUG_MODE_I,
  input wire logic PROG_SERIAL_DATA_I,
  input wire logic PROG_SERIAL_DATA_OUT_I,
  input wire logic PROG_SERIAL_DATA_OE_REQ_I,
  output logic PROG_SERIAL_DATA_O,
  output logic PROG_SERIAL_DATA_OE_O,
  input wire logic DEBUG_SERIAL_CLOCK_I,
  input wire logic DEBUG_SERIAL_DATA_I,
  input wire logic DEBUG_DATA_OUT_I,
  input wire logic DEBUG_DATA_OE_REQ_I,
  output logic DEBUG_SERIAL_DATA_O,
  output logic DEBUG_SERIAL_DATA_OE_O,
  input wire logic PIN_FUNC_OUT_I,
  input wire logic PIN_FUNC_OE_I,
  output logic PIN_FUNC_IN_O
);
  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_WAIT = 2'b10
  } tstate_t;

  logic [11:0] prog_mem [mem_map_pkg::PROG_WORDS];
  logic [7:0] gpr [mem_map_pkg::GPR_BYTES];
  logic [8:0] pc_q;
  logic [7:0] tblp_q;
  logic [7:0] ptr_q;
  logic [3:0] status_q;
  tstate_t ts_q;
  logic [7:0] cnt_q;
  logic [4:0] dest_q;
  logic [8:0] taddr_q;
  logic [7:0] tdata;
  logic [3:0] gidx;
  logic [7:0] cur_byte;
  logic [7:0] new_byte;
  logic tbl_wr;

  // apply a data op to a byte; bit ops touch a single bit
  function automatic logic [7:0] apply_op(input mem_map_pkg::dop_t op,
    input logic [7:0] old, input logic [7:0] wd, input logic [2:0] b);
    logic [7:0] r;
    r = old;
    case (op)
      mem_map_pkg::DOP_WRITE: r = wd;
      mem_map_pkg::DOP_BSET: r[b] = 1'b1;
      mem_map_pkg::DOP_BCLR: r[b] = 1'b0;
      default: r = old;
    endcase
    return r;
  endfunction

  // decode used by read and write paths
  function automatic logic is_gpr(input logic [4:0] a);
    return (a >= mem_map_pkg::GPR_FIRST) && (a <= mem_map_pkg::GPR_LAST);
  endfunction

  // program store load and fetch
  always_ff @(posedge CORE_CLK_I)
  begin
    if (PROG_WE_I)
    begin
      prog_mem[PROG_WADDR_I] <= PROG_WDATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      INSTR_O <= 12'h000;
    end
    else if (FETCH_I)
    begin
      INSTR_O <= prog_mem[pc_q];
    end
  end

  // pc: reset vector, loads, or increment on fetch
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      pc_q <= mem_map_pkg::RESET_VECTOR;
    end
    else if (PC_LOAD_I)
    begin
      pc_q <= PC_LOAD_VAL_I;
    end
    else if (DMEM_REQ_I.op == mem_map_pkg::DOP_WRITE &&
             DMEM_REQ_I.addr == mem_map_pkg::SFR_PC_LOW)
    begin
      pc_q <= {pc_q[8], DMEM_REQ_I.wdata}; // jump stays in page
    end
    else if (FETCH_I)
    begin
      pc_q <= pc_q + 9'h001;
    end
  end
  assign PC_O = pc_q;

  // only the low byte is ever taken
  assign tdata = prog_mem[taddr_q][7:0];
  assign tbl_wr = (ts_q == TS_WAIT) &&
                  (cnt_q == 8'(2 * CYCLES_PER_INSTR - 1));

  // table sequencer holds for two instruction cycles
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      ts_q <= TS_IDLE;
      cnt_q <= 8'h00;
      dest_q <= 5'h00;
      taddr_q <= 9'h000;
    end
    else
    begin
      case (ts_q)
        TS_IDLE:
        begin
          cnt_q <= 8'h00;
          if (TBL_REQ_I.start)
          begin
            ts_q <= TS_WAIT;
            dest_q <= TBL_REQ_I.dest;
            if (TBL_REQ_I.last_page)
            begin
              taddr_q <= mem_map_pkg::LAST_PAGE_BASE | {1'b0, tblp_q};
            end
            else
            begin
              taddr_q <= {pc_q[8], tblp_q};
            end
          end
        end
        TS_WAIT:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (tbl_wr)
          begin
            ts_q <= TS_IDLE;
          end
        end
        default: ts_q <= TS_IDLE;
      endcase
    end
  end
  assign TBL_BUSY_O = (ts_q == TS_WAIT);
  assign TBL_DONE_O = tbl_wr;

  assign gidx = DMEM_REQ_I.addr[3:0];
  always_comb
  begin
    cur_byte = mem_map_pkg::UNUSED_READ;
    if (is_gpr(DMEM_REQ_I.addr))
    begin
      cur_byte = gpr[gidx];
    end
    else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_POINTER)
    begin
      cur_byte = ptr_q;
    end
    else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_PC_LOW)
    begin
      cur_byte = pc_q[7:0];
    end
    else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_TABLE_PTR)
    begin
      cur_byte = tblp_q;
    end
    else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_STATUS)
    begin
      cur_byte = {4'h0, status_q};
    end
    else
    begin
      cur_byte = mem_map_pkg::UNUSED_READ;
    end
  end
  assign new_byte = apply_op(DMEM_REQ_I.op, cur_byte, DMEM_REQ_I.wdata,
                             DMEM_REQ_I.bit_sel);

  // general purpose bytes, table result lands here too
  always_ff @(posedge CORE_CLK_I)
  begin
    if (tbl_wr && is_gpr(dest_q))
    begin
      gpr[dest_q[3:0]] <= tdata;
    end
    else if (DMEM_REQ_I.op != mem_map_pkg::DOP_NONE &&
             is_gpr(DMEM_REQ_I.addr))
    begin
      gpr[gidx] <= new_byte;
    end
  end

  // table pointer kept apart from the pc
  // special registers; status keeps its protected bits
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      tblp_q <= mem_map_pkg::RESET_BYTE;
      ptr_q <= mem_map_pkg::RESET_BYTE;
      status_q <= 4'h0;
    end
    else if (tbl_wr && dest_q == mem_map_pkg::SFR_TABLE_PTR)
    begin
      tblp_q <= tdata;
    end
    else if (DMEM_REQ_I.op != mem_map_pkg::DOP_NONE)
    begin
      if (DMEM_REQ_I.addr == mem_map_pkg::SFR_TABLE_PTR)
      begin
        tblp_q <= new_byte;
      end
      else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_POINTER)
      begin
        ptr_q <= new_byte;
      end
      else if (DMEM_REQ_I.addr == mem_map_pkg::SFR_STATUS)
      begin
        status_q <= new_byte[3:0] & mem_map_pkg::STATUS_WR_MASK[3:0];
      end
    end
  end

  // registered read data
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      DMEM_RDATA_O <= 8'h00;
    end
    else
    begin
      DMEM_RDATA_O <= cur_byte;
    end
  end

  // programming data pin, driven only when asked
  assign PROG_SERIAL_DATA_O = PROG_SERIAL_DATA_OUT_I;
  assign PROG_SERIAL_DATA_OE_O = PROG_SERIAL_DATA_OE_REQ_I;
  // debug data two-way; debug clock is input only
  // shared function drives the pin only outside debug
  assign DEBUG_SERIAL_DATA_O = DEBUG_MODE_I ? DEBUG_DATA_OUT_I :
                               PIN_FUNC_OUT_I;
  // shared pin function silenced while debugging
  assign DEBUG_SERIAL_DATA_OE_O = DEBUG_MODE_I ? DEBUG_DATA_OE_REQ_I :
                                  PIN_FUNC_OE_I;
  assign PIN_FUNC_IN_O = DEBUG_MODE_I ? 1'b0 : DEBUG_SERIAL_DATA_I;
endmodule // mem_map

// >>> mem_map_monitor.sv
`timescale 1ns/1ps
// pc, table timing and data map seen at the ports
module mem_map_monitor #(
  parameter int CYCLES_PER_INSTR = 4
) (
  // clock, reset and pc
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic FETCH_I,
  input wire logic PC_LOAD_I,
  input wire logic [8:0] PC_LOAD_VAL_I,
  input wire logic [8:0] PC_O,
  // data, table and pins
  input wire mem_map_pkg::dmem_req_t DMEM_REQ_I,
  input wire mem_map_pkg::tbl_req_t TBL_REQ_I,
  input wire logic [7:0] DMEM_RDATA_O,
  input wire logic TBL_BUSY_O,
  input wire logic TBL_DONE_O,
  input wire logic DEBUG_MODE_I,
  input wire logic PIN_FUNC_IN_O
);
  logic [7:0] age_q;
  logic [4:0] ad;
  logic idle;
  assign ad = DMEM_REQ_I.addr;
  assign idle = DMEM_REQ_I.op == mem_map_pkg::DOP_NONE;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // busy age, so done is held to its exact slot
  always_ff @(posedge CORE_CLK_I)
    age_q <= (SRST_I || !TBL_BUSY_O) ? 8'h01 : age_q + 8'h01;
  sequence gpr_write_read;
    DMEM_REQ_I.op == mem_map_pkg::DOP_WRITE && ad[4] && !TBL_DONE_O
    ##1 idle && ad == $past(ad);
  endsequence
  pc_after_reset_a:
    assert property ($fell(SRST_I) |-> PC_O == 9'h000) else $error("pc");
  pc_load_a:
    assert property (PC_LOAD_I |=> PC_O == $past(PC_LOAD_VAL_I))
    else $error("pc load");
  pc_step_a:
    assert property (FETCH_I && !PC_LOAD_I && (idle || ad != 5'h06)
      |=> PC_O == $past(PC_O) + 9'h001) else $error("pc step");
  tbl_done_slot_a:
    assert property (TBL_DONE_O |-> age_q == 8'(2 * CYCLES_PER_INSTR))
    else $error("table slot");
  tbl_start_busy_a:
    assert property (TBL_REQ_I.start && !TBL_BUSY_O |=> TBL_BUSY_O)
    else $error("table start");
  tbl_done_end_a:
    assert property (TBL_DONE_O |-> TBL_BUSY_O ##1 !TBL_BUSY_O)
    else $error("table end");
  gpr_rw_a:
    assert property (gpr_write_read |=> DMEM_RDATA_O ==
      $past(DMEM_REQ_I.wdata, 2)) else $error("gpr byte");
  unused_read_a:
    assert property (idle && !ad[4] && !(ad inside {5'h01, 5'h06, 5'h07,
      5'h0a}) |=> DMEM_RDATA_O == 8'h00) else $error("unused byte");
  status_ro_a:
    assert property (ad == 5'h0a |=> DMEM_RDATA_O[7:4] == 4'h0)
    else $error("status top");
  debug_iso_a:
    assert property (DEBUG_MODE_I |-> !PIN_FUNC_IN_O) else $error("pin");
endmodule // mem_map_monitor

// >>> core_model.sv
`timescale 1ns/1ps
// core side: one request per call, driven just after the edge
module core_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic done,
  output logic fetch,
  output logic pc_load,
  output logic [8:0] pc_val,
  output mem_map_pkg::dmem_req_t dmem,
  output mem_map_pkg::tbl_req_t tbl
);
  // idle before reset ends
  initial
  begin
    fetch = 1'b0;
    pc_load = 1'b0;
    pc_val = 9'h000;
    dmem = '0;
    tbl = '0;
  end
  task automatic step(input logic ld, input logic [8:0] v);
    @(posedge clk);
    #1 fetch = !ld;
    pc_load = ld;
    pc_val = v;
    @(posedge clk);
    #1 fetch = 1'b0;
    pc_load = 1'b0;
  endtask
  // read byte is the one held before this edge
  task automatic dop(input logic [1:0] op, input logic [4:0] a,
    input logic [7:0] wd, input logic [2:0] b, output logic [7:0] rd);
    @(posedge clk);
    #1 dmem = '{mem_map_pkg::dop_t'(op), a, wd, b};
    @(posedge clk);
    #1 rd = rdata;
    dmem.op = mem_map_pkg::DOP_NONE;
  endtask
  // start held for one cycle, done awaited under a bound
  task automatic tread(input logic last, output int cyc);
    @(posedge clk);
    #1 tbl = '{1'b1, last, 5'h10};
    @(posedge clk);
    #1 tbl.start = 1'b0;
    cyc = 1;
    while (!done && cyc < 99)
    begin
      @(posedge clk);
      #1 cyc++;
    end
  endtask
endmodule // core_model

// >>> tb_mem_map.sv
`timescale 1ns/1ps
// the map driven through the core model
module tb_mem_map;
  logic CORE_CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic we = 1'b0;
  logic [8:0] wa = 9'h000;
  logic [11:0] wd = 12'h000;
  logic [5:0] pin = 6'h00;
  logic fetch, pc_load, busy, done, pfo, pfe, dbo, dbe, pfi;
  logic [8:0] pc_val, pc;
  logic [11:0] instr;
  logic [11:0] store [512];
  logic [7:0] rdata, rd, tp;
  mem_map_pkg::dmem_req_t dmem;
  mem_map_pkg::tbl_req_t tbl;
  int miscompares = 0;
  int check_count = 0;
  int cyc;
  always #50 CORE_CLK_I = ~CORE_CLK_I;
  core_model u_core (.clk(CORE_CLK_I), .rdata(rdata), .done(done),
    .fetch(fetch), .pc_load(pc_load), .pc_val(pc_val), .dmem(dmem),
    .tbl(tbl));
  mem_map #(.CYCLES_PER_INSTR(4)) u_dut (.CORE_CLK_I(CORE_CLK_I),
    .SRST_I(SRST_I), .FETCH_I(fetch), .PC_LOAD_I(pc_load),
    .PC_LOAD_VAL_I(pc_val), .PC_O(pc), .INSTR_O(instr), .DMEM_REQ_I(dmem),
    .DMEM_RDATA_O(rdata), .TBL_REQ_I(tbl), .TBL_BUSY_O(busy),
    .TBL_DONE_O(done), .PROG_WE_I(we), .PROG_WADDR_I(wa), .PROG_WDATA_I(wd),
    .DEBUG_MODE_I(pin[0]), .PROG_SERIAL_DATA_I(1'b0),
    .PROG_SERIAL_DATA_OUT_I(pin[4]), .PROG_SERIAL_DATA_OE_REQ_I(pin[5]),
    .PROG_SERIAL_DATA_O(pfo), .PROG_SERIAL_DATA_OE_O(pfe),
    .DEBUG_SERIAL_CLOCK_I(1'b0), .DEBUG_SERIAL_DATA_I(pin[2]),
    .DEBUG_DATA_OUT_I(pin[4]), .DEBUG_DATA_OE_REQ_I(pin[3]),
    .DEBUG_SERIAL_DATA_O(dbo), .DEBUG_SERIAL_DATA_OE_O(dbe),
    .PIN_FUNC_OUT_I(~pin[4]), .PIN_FUNC_OE_I(pin[1]), .PIN_FUNC_IN_O(pfi));
  task automatic chk(input string n, input logic [11:0] e,
    input logic [11:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic load(input logic [8:0] a, input logic [11:0] d);
    @(posedge CORE_CLK_I);
    #1 we = 1'b1;
    wa = a;
    wd = d;
    store[a] = d;
    @(posedge CORE_CLK_I);
    #1 we = 1'b0;
  endtask
  // main sequence; the second initial cuts a hang short
  initial
  begin
    repeat (6) @(posedge CORE_CLK_I);
    #1 SRST_I = 1'b0;
    load(9'h000, 12'h5a7);
    chk("pc", 12'h000, {3'h0, pc});
    u_core.step(1'b0, 9'h000);
    chk("instr", 12'h5a7, instr);
    chk("pc", 12'h001, {3'h0, pc});
    SRST_I = 1'b1;
    @(posedge CORE_CLK_I);
    #1 SRST_I = 1'b0;
    chk("pc", 12'h000, {3'h0, pc});
    load(9'h106, 12'hf1a);
    load(9'h006, 12'h933);
    load(9'h107, 12'hec5);
    load(9'h007, 12'h0d2);
    for (int i = 0; i < 3; i++)
    begin
      wa = (i == 2) ? 9'h1f0 : 9'h000;
      tp = (i == 2) ? 8'h07 : 8'h06;
      u_core.step(1'b1, wa);
      u_core.dop(2'h1, 5'h07, tp, 3'h0, rd);
      u_core.tread(i == 0, cyc);
      chk("cycles", 12'h008, 12'(cyc));
      wa = (i == 0) ? 9'h100 + {1'b0, tp} : {wa[8], tp};
      u_core.dop(2'h0, 5'h10, 8'h00, 3'h0, rd);
      chk("table", {4'h0, store[wa][7:0]}, {4'h0, rd});
    end
    for (int a = 0; a < 32; a++)
    begin
      if (a == 6)
        continue;
      u_core.dop(2'h1, 5'(a), 8'hf5, 3'h0, rd);
      u_core.dop(2'h0, 5'(a), 8'h00, 3'h0, rd);
      tp = (a > 15 || a == 1 || a == 7) ? 8'hf5 : 8'h00;
      tp = (a == 10) ? mem_map_pkg::STATUS_WR_MASK & 8'hf5 : tp;
      chk("byte", {4'h0, tp}, {4'h0, rd});
    end
    u_core.dop(2'h3, 5'h1f, 8'h00, 3'h0, rd);
    u_core.dop(2'h2, 5'h10, 8'h00, 3'h3, rd);
    u_core.dop(2'h0, 5'h1f, 8'h00, 3'h0, rd);
    chk("bclr", 12'h0f4, {4'h0, rd});
    u_core.dop(2'h0, 5'h10, 8'h00, 3'h0, rd);
    chk("bset", 12'h0fd, {4'h0, rd});
    for (int m = 0; m < 2; m++)
    begin
      @(posedge CORE_CLK_I);
      #1 pin = 6'h36 | 6'(m);
      #1 chk("pins", m ? 12'h007 : 12'h01b,
             12'({dbe, pfi, dbo, pfe, pfo}));
    end
    tally_and_finish();
  end
  initial
  begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule // tb_mem_map
bind mem_map mem_map_monitor #(.CYCLES_PER_INSTR(CYCLES_PER_INSTR)) u_mon (
  .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .FETCH_I(FETCH_I),
  .PC_LOAD_I(PC_LOAD_I), .PC_LOAD_VAL_I(PC_LOAD_VAL_I), .PC_O(PC_O),
  .DMEM_REQ_I(DMEM_REQ_I), .TBL_REQ_I(TBL_REQ_I),
  .DMEM_RDATA_O(DMEM_RDATA_O),
  .TBL_BUSY_O(TBL_BUSY_O), .TBL_DONE_O(TBL_DONE_O),
  .DEBUG_MODE_I(DEBUG_MODE_I), .PIN_FUNC_IN_O(PIN_FUNC_IN_O));
